// ==== logic/embp_port.sv ====
// External memory bus port: address, data, selects, strobes and I/O window decode
// Functional notes
// - Address holds last value when idle
// - Address floats during reset
// - Data lines float when bus idle
// - Data lines float during reset
// - All bus controls float during reset
// - Program select low only for program and vector access
// - Program select changes with address lines
// - Program select driven high when idle
// - Data select low only for data access
// - Data select driven high when idle
// - Bank select marks X or Y space
// - Read strobe low for whole read
// - Data lines are inputs during read
// - Read data captured at strobe release
// - Selects valid while read strobe low
// - Write strobe low during each write
// - Write data driven while write strobe low
// - Decode low for Y FFC0 to FFFF
// - Decode floats during reset
// - Select encoding: idle, X, Y, program, vector
`include "embp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Transfer timing, one strobe phase of STROBE_CYC cycles
//   edge 0              : request taken
//   edge 0              : address, selects and decode load
//   edge 0              : read or write strobe goes low with them
//   edge 1              : strobe held low, width counter runs
//   edge STROBE_CYC     : strobe released
//   edge STROBE_CYC     : read data latched from the data lines
//   edge STROBE_CYC + 1 : selects and decode back to idle
//   edge STROBE_CYC + 1 : ready again for the next request
//
// Address lines keep their value between transfers, so a
// memory that decodes late still sees a steady address.
// Data lines are driven only under the write strobe; under
// the read strobe and when idle they are left to the far side.
// All pin enables are low in reset; all but the data enable rise one edge after it.
//
// Hazards
//   A new request is refused until the idle select code has
//   been shown for a cycle, so selects never glitch straight
//   from one space into another between two transfers.
//   Both strobes come from one direction bit and one phase,
//   so they can never be low together.
//   Reserved select codes never leave this block: the space
//   type maps only onto the four legal codes.
//   Write data stays on the lines for the whole strobe, so
//   the memory may latch it at the releasing edge.
//
// Limits
//   The strobe width is fixed by STROBE_CYC; no wait input.
//   Read data is held until the next read completes.
////////////////////////////////////////////////////////////////////////////////

module embp_port #(
    parameter int STROBE_CYC = `EMBP_STROBE_CYC
) (
    input  wire logic                     ref_clk,
    input  wire logic                     arst_n,
    input  wire embp_pkg::embp_req_t      req,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    output logic [`EMBP_DATA_W-1:0]       rdata,
    output logic                          rdata_valid,
    output logic [`EMBP_ADDR_W-1:0]       address_lines,
    output logic                          address_lines_oe,
    output logic [`EMBP_DATA_W-1:0]       data_lines_o,
    output logic                          data_lines_oe,
    input  wire logic [`EMBP_DATA_W-1:0]  data_lines_i,
    output logic                          program_space_select_n,
    output logic                          data_space_select_n,
    output logic                          bank_select,
    output logic                          read_strobe_n,
    output logic                          write_strobe_n,
    output logic                          ctrl_oe,
    output logic                          io_window_decode_n,
    output logic                          io_window_decode_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Select code as program, data, bank
    function automatic logic [2:0] sel_code(input embp_pkg::embp_space_t sp);
        unique case (sp)
            embp_pkg::EMBP_SP_X:    sel_code = `EMBP_SEL_XDATA;
            embp_pkg::EMBP_SP_Y:    sel_code = `EMBP_SEL_YDATA;
            embp_pkg::EMBP_SP_PROG: sel_code = `EMBP_SEL_PROG;
            embp_pkg::EMBP_SP_VECT: sel_code = `EMBP_SEL_VECT;
            default:                sel_code = `EMBP_SEL_IDLE;
        endcase
    endfunction

    // Accesses into the top 64 words of Y space
    function automatic logic in_io_window(input embp_pkg::embp_space_t sp,
                                          input logic [15:0] a);
        in_io_window = (sp == embp_pkg::EMBP_SP_Y) && (a >= `EMBP_IO_WIN_BASE);
    endfunction

    localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // State

    embp_pkg::embp_state_t   state_ff;
    embp_pkg::embp_state_t   nxt_state;
    logic [7:0]              cnt_ff;
    logic [15:0]             addr_ff;
    logic [2:0]              sel_ff;
    logic                    write_ff;
    logic [23:0]             wdata_ff;
    logic                    decode_ff;
    logic                    rd_ff;
    logic                    wr_ff;
    logic                    out_en_ff;
    logic [23:0]             rdata_ff;
    logic                    rvalid_ff;
    logic                    accept;

    // One transfer at a time; new request only while idle
    assign req_ready = (state_ff == embp_pkg::EMBP_ST_IDLE) && out_en_ff;
    assign accept    = req_ready && req_valid;

    // Sequencer: idle, strobe phase, release cycle
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            embp_pkg::EMBP_ST_IDLE: begin
                if (accept) begin
                    nxt_state = embp_pkg::EMBP_ST_STROBE;
                end
            end
            embp_pkg::EMBP_ST_STROBE: begin
                if (cnt_ff == STROBE_LAST) begin
                    nxt_state = embp_pkg::EMBP_ST_END;
                end
            end
            embp_pkg::EMBP_ST_END: begin
                nxt_state = embp_pkg::EMBP_ST_IDLE;
            end
            default: nxt_state = embp_pkg::EMBP_ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= embp_pkg::EMBP_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Strobe width counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 8'h00;
        end else if (state_ff == embp_pkg::EMBP_ST_STROBE) begin
            cnt_ff <= cnt_ff + 8'h01;
        end else begin
            cnt_ff <= 8'h00;
        end
    end

    // Enables come up one edge after reset release
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_en_ff <= 1'b0;
        end else begin
            out_en_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address, selects and decode, all loaded together at acceptance

    // Address held between transfers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff <= 16'h0000;
        end else if (accept) begin
            addr_ff <= req.addr;
        end
    end

    // Select code, driven high when no transfer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_ff <= `EMBP_SEL_IDLE;
        end else if (accept) begin
            sel_ff <= sel_code(req.space);
        end else if (state_ff == embp_pkg::EMBP_ST_END) begin
            sel_ff <= `EMBP_SEL_IDLE;
        end
    end

    // I/O window decode follows the selects
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            decode_ff <= 1'b0;
        end else if (accept) begin
            decode_ff <= in_io_window(req.space, req.addr);
        end else if (state_ff == embp_pkg::EMBP_ST_END) begin
            decode_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes and data

    logic                    nxt_write;
    logic                    strobe_phase;
    logic                    rd_release;

    // Direction of the coming strobe phase: new request or the held one
    assign nxt_write = accept ? req.write : write_ff;

    // Strobe phase runs from acceptance to the last counted cycle
    assign strobe_phase = (nxt_state == embp_pkg::EMBP_ST_STROBE);

    // Read strobe is released at this edge
    assign rd_release = rd_ff && !strobe_phase;

    // Direction captured at acceptance
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            write_ff <= 1'b0;
        end else if (accept) begin
            write_ff <= req.write;
        end
    end

    // Write data captured at acceptance, stands through the strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdata_ff <= 24'h000000;
        end else if (accept) begin
            wdata_ff <= req.wdata;
        end
    end

    // Read strobe low through the strobe phase of a read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_ff <= 1'b0;
        end else begin
            rd_ff <= strobe_phase && !nxt_write;
        end
    end

    // Write strobe low through the strobe phase of a write
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff <= 1'b0;
        end else begin
            wr_ff <= strobe_phase && nxt_write;
        end
    end

    // One-cycle flag that fresh read data stands
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= rd_release;
        end
    end

    // Read data latched when the read strobe releases
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 24'h000000;
        end else if (rd_release) begin
            rdata_ff <= data_lines_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Address bus, floated in reset
    assign address_lines          = addr_ff;
    assign address_lines_oe       = out_en_ff;

    // Select code split onto its three pins
    assign program_space_select_n = sel_ff[2];
    assign data_space_select_n    = sel_ff[1];
    assign bank_select            = sel_ff[0];

    // Active-low strobes
    assign read_strobe_n          = !rd_ff;
    assign write_strobe_n         = !wr_ff;

    // One enable for all five bus controls
    assign ctrl_oe                = out_en_ff;

    // I/O window decode and its enable
    assign io_window_decode_n     = !decode_ff;
    assign io_window_decode_oe    = out_en_ff;

    // Data driven only under the write strobe; input otherwise
    assign data_lines_o           = wdata_ff;
    assign data_lines_oe          = wr_ff && out_en_ff;

    // Read result towards the core
    assign rdata                  = rdata_ff;
    assign rdata_valid            = rvalid_ff;

endmodule
`default_nettype wire

// ==== common/embp_defines.svh ====
// Constants for the external memory bus port
`ifndef EMBP_DEFINES_SVH
`define EMBP_DEFINES_SVH

`define EMBP_ADDR_W        16
`define EMBP_DATA_W        24
`define EMBP_IO_WIN_BASE   16'hFFC0
`define EMBP_SEL_IDLE      3'h7
`define EMBP_SEL_XDATA     3'h5
`define EMBP_SEL_YDATA     3'h4
`define EMBP_SEL_PROG      3'h3
`define EMBP_SEL_VECT      3'h2
`define EMBP_STROBE_NS     8
`define EMBP_CLK_NS        4
`define EMBP_STROBE_CYC    ((`EMBP_STROBE_NS + `EMBP_CLK_NS - 1) / `EMBP_CLK_NS)

`endif

// ==== common/embp_pkg.sv ====
// Types for the external memory bus port
`default_nettype none
package embp_pkg;

    // Space chosen by the core for one external transfer
    typedef enum logic [2:0] {
        EMBP_SP_X    = 3'h0,
        EMBP_SP_Y    = 3'h1,
        EMBP_SP_PROG = 3'h2,
        EMBP_SP_VECT = 3'h3
    } embp_space_t;

    // Transfer request from the core
    typedef struct packed {
        embp_space_t  space;
        logic         write;
        logic [15:0]  addr;
        logic [23:0]  wdata;
    } embp_req_t;

    // Bus sequencer states
    typedef enum logic [1:0] {
        EMBP_ST_IDLE   = 2'b00,
        EMBP_ST_STROBE = 2'b01,
        EMBP_ST_END    = 2'b10
    } embp_state_t;

endpackage
`default_nettype wire

// ==== sim/embp_port_props.sv ====
// Pin-level checker for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module embp_port_props #(
    parameter int STROBE_CYC = 2
) (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [23:0] rdata,
    input wire logic        rdata_valid,
    input wire logic [15:0] address_lines,
    input wire logic        address_lines_oe,
    input wire logic        data_lines_oe,
    input wire logic [23:0] data_lines_i,
    input wire logic        program_space_select_n,
    input wire logic        data_space_select_n,
    input wire logic        bank_select,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        ctrl_oe,
    input wire logic        io_window_decode_n,
    input wire logic        io_window_decode_oe
);
    logic [2:0] sel;
    logic       busy;
    logic [7:0] low_cnt_ff;
    // Select code and strobe activity
    assign sel  = {program_space_select_n, data_space_select_n, bank_select};
    assign busy = !read_strobe_n || !write_strobe_n;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Counts strobe-low cycles of the running transfer
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) low_cnt_ff <= 8'h00;
        else low_cnt_ff <= busy ? low_cnt_ff + 8'h01 : 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_one_strobe; !(!read_strobe_n && !write_strobe_n); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_data_oe; data_lines_oe == !write_strobe_n; endproperty
    a_data_oe: assert property (p_data_oe) else $error("data enable off strobe");
    property p_addr_hold; !busy && !$past(busy) |-> $stable(address_lines); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved idle");
    property p_len; $rose(read_strobe_n) || $rose(write_strobe_n) |-> low_cnt_ff == STROBE_CYC;
    endproperty
    a_len: assert property (p_len) else $error("strobe length");
    property p_idle; $rose(read_strobe_n) || $rose(write_strobe_n) |=> sel == 3'h7; endproperty
    a_idle: assert property (p_idle) else $error("selects not idle");
    property p_code; busy |-> sel inside {3'h5, 3'h4, 3'h3, 3'h2}; endproperty
    a_code: assert property (p_code) else $error("bad select code");
    property p_decode; busy |-> io_window_decode_n == !(sel == 3'h4 && address_lines >= 16'hFFC0);
    endproperty
    a_decode: assert property (p_decode) else $error("window decode");
    property p_rdata; rdata_valid |-> $rose(read_strobe_n) && rdata == $past(data_lines_i);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read capture");
    property p_float;
        @(posedge ref_clk) disable iff (1'b0)
        !arst_n |-> !(address_lines_oe || data_lines_oe || ctrl_oe || io_window_decode_oe);
    endproperty
    a_float: assert property (p_float) else $error("pins driven in reset");
    // Main traffic kinds
    c_read: cover property ($rose(read_strobe_n));
    c_write: cover property ($rose(write_strobe_n));
    c_window: cover property (!io_window_decode_n);
endmodule
bind embp_port embp_port_props #(.STROBE_CYC(STROBE_CYC)) u_embp_port_props (
    .ref_clk, .arst_n, .rdata, .rdata_valid, .address_lines, .address_lines_oe,
    .data_lines_oe, .data_lines_i, .program_space_select_n, .data_space_select_n,
    .bank_select, .read_strobe_n, .write_strobe_n, .ctrl_oe, .io_window_decode_n,
    .io_window_decode_oe);
`default_nettype wire

// ==== sim/embp_mem_model.sv ====
// Static memory on the far side of the external bus, also resolves the data wire
`timescale 1ns/1ps
`default_nettype none
module embp_mem_model (
    input wire logic        ref_clk,
    input wire logic        slow,
    input wire logic [15:0] address_lines,
    input wire logic [2:0]  sel,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [23:0] data_lines_o,
    input wire logic        data_lines_oe,
    output logic [23:0]     data_lines_i
);
    logic [23:0] mem [logic [18:0]];
    logic [23:0] last;
    logic        late_ff;
    initial last = 24'hA5A5A5;
    // Last word seen under the write strobe is what its release latches
    always @(negedge ref_clk) begin
        if (!write_strobe_n) mem[{sel, address_lines}] = data_lines_i;
        last <= data_lines_i;
        late_ff <= !read_strobe_n;
    end
    // Drive only under the read strobe; a slow part is valid half a cycle late
    always @* begin
        if (data_lines_oe) data_lines_i = data_lines_o;
        else if (!read_strobe_n && (!slow || late_ff)) data_lines_i = mem[{sel, address_lines}];
        else data_lines_i = ~last;
    end
endmodule
`default_nettype wire

// ==== sim/tb_external_memory_bus_port.sv ====
// Testbench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_bus_port;
    logic                ref_clk, arst_n, slow, req_valid, req_ready, rdata_valid;
    embp_pkg::embp_req_t req;
    logic [23:0]         rdata, data_lines_o, data_lines_i;
    logic [15:0]         address_lines;
    logic                address_lines_oe, data_lines_oe, program_space_select_n;
    logic                data_space_select_n, bank_select, read_strobe_n, write_strobe_n;
    logic                ctrl_oe, io_window_decode_n, io_window_decode_oe;
    logic [23:0]         exp_mem [logic [18:0]];
    int                  bad_count, comparisons;
    embp_port #(.STROBE_CYC(2)) u_embp_port (.ref_clk, .arst_n, .req, .req_valid, .req_ready,
        .rdata, .rdata_valid, .address_lines, .address_lines_oe, .data_lines_o,
        .data_lines_oe, .data_lines_i, .program_space_select_n, .data_space_select_n,
        .bank_select, .read_strobe_n, .write_strobe_n, .ctrl_oe, .io_window_decode_n,
        .io_window_decode_oe);
    embp_mem_model u_embp_mem_model (.ref_clk, .slow, .address_lines, .read_strobe_n,
        .sel({program_space_select_n, data_space_select_n, bank_select}),
        .write_strobe_n, .data_lines_o, .data_lines_oe, .data_lines_i);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One whole transfer, judged after acceptance, after the read strobe releases, and back at idle
    task automatic xfer(input logic [2:0] sp, input logic wr, input logic [15:0] ad,
                        input logic [23:0] wd);
        logic [2:0] code;
        int         n;
        code = (sp == 3'h0) ? 3'h5 : (sp == 3'h1) ? 3'h4 : (sp == 3'h2) ? 3'h3 : 3'h2;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk(req_ready, 1'b1);
        if (wr) exp_mem[{sp, ad}] = wd;
        req = '{embp_pkg::embp_space_t'(sp), wr, ad, wd};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk({program_space_select_n, data_space_select_n, bank_select}, code);
        chk(io_window_decode_n, !(sp == 3'h1 && ad >= 16'hFFC0));
        chk(req_ready, 1'b0);
        chk({address_lines, read_strobe_n, write_strobe_n, data_lines_oe},
            {ad, wr, !wr, wr});
        if (wr) chk(data_lines_i, wd);
        repeat (2) @(negedge ref_clk);
        if (!wr) chk({rdata_valid, rdata}, {1'b1, exp_mem[{sp, ad}]});
        @(negedge ref_clk);
        chk({program_space_select_n, data_space_select_n, bank_select, address_lines,
             data_lines_oe, read_strobe_n, write_strobe_n}, {3'h7, ad, 3'h3});
    endtask
    // Same address in all four spaces: writes first, then reads
    task automatic t_spaces();
        for (int i = 0; i < 8; i++) begin
            xfer(3'(i % 4), i < 4, 16'h0100, 24'(24'h111111 * (i % 4 + 1)));
        end
    endtask
    // Edges of the I/O window in Y, and the same address in X
    task automatic t_window();
        logic [15:0] adr [4];
        adr = '{16'hFFBF, 16'hFFC0, 16'hFFFF, 16'hFFC0};
        for (int i = 0; i < 4; i++) begin
            xfer({2'h0, i < 3}, 1'b1, adr[i], {8'h5C, adr[i]});
            xfer({2'h0, i < 3}, 1'b0, adr[i], 24'h0);
        end
    endtask
    // A memory that answers late still reads back correctly
    task automatic t_slow();
        slow = 1'b1;
        xfer(3'h1, 1'b1, 16'h2222, 24'h123456);
        xfer(3'h1, 1'b0, 16'h2222, 24'h0);
        slow = 1'b0;
    endtask
    // Reset landing in mid-write floats every pin, then traffic resumes
    task automatic t_reset();
        req = '{embp_pkg::EMBP_SP_X, 1'b1, 16'h0042, 24'h00BEEF};
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        arst_n = 1'b0;
        #1;
        chk({address_lines_oe, data_lines_oe, ctrl_oe, io_window_decode_oe}, 32'h0);
        @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        xfer(3'h0, 1'b0, 16'h0100, 24'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Traffic takes well under a microsecond; this leaves a wide margin
    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        arst_n = 1'b0;
        slow = 1'b0;
        req = '0;
        req_valid = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_spaces();
        t_window();
        t_slow();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
